// ===== verilog/orient_pkg.sv
// package: register map, field layout, reset values, fixed angle codes and timing constants
package orient_pkg;

	// ==========================================================
	// register indices (byte address is four times the index)
	localparam logic [5:0] IDX_STATUS = 6'h10;
	localparam logic [5:0] IDX_CONFIG = 6'h11;
	localparam logic [5:0] IDX_DBNC_COUNT = 6'h12;
	localparam logic [5:0] IDX_FACING_TILT = 6'h13;
	localparam logic [5:0] IDX_THRESHOLD = 6'h14;

	// ==========================================================
	// field positions
	localparam int STAT_CHANGE_BIT = 7;
	localparam int STAT_ZTILT_BIT = 6;
	localparam int STAT_CODE_LSB = 1;
	localparam int STAT_FACING_BIT = 0;
	localparam int CFG_MODE_BIT = 7;
	localparam int CFG_ENABLE_BIT = 6;
	localparam int CMP_FACING_LSB = 6;
	localparam int THS_TRIP_LSB = 3;

	// ==========================================================
	// reset values and fixed read-only codes
	localparam logic MODE_RST = 1'b1;
	localparam logic ENABLE_RST = 1'b0;
	localparam logic [7:0] DBNC_RST = 8'h00;
	localparam logic [1:0] CODE_RST = 2'h0;
	localparam logic [1:0] FACING_TRIP_CODE = 2'h1;
	localparam logic [2:0] ZTILT_LIMIT_CODE = 3'h4;
	localparam logic [4:0] ORIENT_TRIP_CODE = 5'h10;
	localparam logic [2:0] TRIP_MARGIN_CODE = 3'h4;

	// ==========================================================
	// angle tangents, cosines and g limit in Q8 fixed point
	localparam logic [9:0] TAN31_Q8 = 10'h09A;
	localparam logic [9:0] TAN59_Q8 = 10'h1AA;
	localparam logic [9:0] TAN29_Q8 = 10'h08E;
	localparam logic [9:0] COS75_Q8 = 10'h042;
	localparam logic [9:0] LIMIT_G_Q8 = 10'h140;

	// ==========================================================
	// timing: base debounce step is 1.25 ms
	localparam int CLK_PERIOD_PS = 25000;
	localparam int STEP_BASE_PS = 1250000000;
	localparam int STEP_BASE_CYCLES = STEP_BASE_PS / CLK_PERIOD_PS;

	typedef enum logic [1:0] {
		OSM_NORMAL = 2'b00,
		OSM_QUIET_LOW_POWER = 2'b01,
		OSM_HIGH_RES = 2'b10,
		OSM_LOW_POWER = 2'b11
	} osm_type;

	// step length in base steps; rate 0..7 is 800,400,200,100,50,12.5,6.25,1.56 Hz
	function automatic logic [7:0] step_mult(input logic [2:0] rate, input logic [1:0] osm);
		logic [7:0] m;
		m = 8'h01;
		case (rate)
			3'h0: m = 8'h01;
			3'h1: m = 8'h02;
			3'h2: m = 8'h04;
			3'h3: m = 8'h08;
			3'h4: m = 8'h10;
			default: m = 8'h10;
		endcase
		if (rate >= 3'h5 && osm != OSM_NORMAL) begin
			m = 8'h40;
		end
		if (rate >= 3'h6 && osm == OSM_LOW_POWER) begin
			m = 8'h80;
		end
		if (osm == OSM_HIGH_RES && rate != 3'h0) begin
			m = 8'h02;
		end
		return m;
	endfunction : step_mult

endpackage : orient_pkg

// ===== verilog/orient_classify.sv
// orient_classify: candidate orientation, facing and tilt lockout from one acceleration sample
`timescale 1ns/100ps
module orient_classify #(
	parameter int AW = 12,
	parameter int ONE_G = 1024
) (
	input wire logic [AW-1:0] accel_x,
	input wire logic [AW-1:0] accel_y,
	input wire logic [AW-1:0] accel_z,
	input wire logic [1:0] cur_code,
	input wire logic cur_facing,
	output logic [1:0] cand_code,
	output logic cand_facing,
	output logic cand_ztilt,
	output logic over_limit
);
	localparam int PW = AW + 11;
	localparam logic [PW-1:0] FACING_THR = PW'(ONE_G) * PW'(orient_pkg::COS75_Q8);
	localparam logic [PW-1:0] LIMIT_THR = PW'(ONE_G) * PW'(orient_pkg::LIMIT_G_Q8);

	logic signed [AW:0] sx, sy, sz;
	logic [AW:0] ax, ay, az, amax;
	logic [PW-1:0] ax_q8, ay_q8, az_q8, amax_q8;

	// ==========================================================
	// magnitudes, widened so the most negative code still fits
	assign sx = {accel_x[AW-1], accel_x};
	assign sy = {accel_y[AW-1], accel_y};
	assign sz = {accel_z[AW-1], accel_z};
	assign ax = sx[AW] ? $unsigned(-sx) : $unsigned(sx);
	assign ay = sy[AW] ? $unsigned(-sy) : $unsigned(sy);
	assign az = sz[AW] ? $unsigned(-sz) : $unsigned(sz);
	assign amax = (ax > ay) ? ax : ay;
	assign ax_q8 = PW'({ax, 8'h00});
	assign ay_q8 = PW'({ay, 8'h00});
	assign az_q8 = PW'({az, 8'h00});
	assign amax_q8 = PW'({amax, 8'h00});

	// ==========================================================
	// hysteresis: leave portrait below 31 deg, leave landscape above 59 deg
	always_comb begin
		cand_code = cur_code;
		if (!cur_code[1]) begin
			if (ay_q8 < PW'(ax) * PW'(orient_pkg::TAN31_Q8)) begin
				cand_code = {1'b1, accel_x[AW-1]};
			end else begin
				cand_code = {1'b0, accel_y[AW-1]};
			end
		end else begin
			if (ay_q8 > PW'(ax) * PW'(orient_pkg::TAN59_Q8)) begin
				cand_code = {1'b0, accel_y[AW-1]};
			end else begin
				cand_code = {1'b1, accel_x[AW-1]};
			end
		end
	end

	// facing changes only within 75 deg of horizontal; at steeper tilt the last facing stands
	assign cand_facing = (az_q8 >= FACING_THR) ? accel_z[AW-1] : cur_facing;
	// lockout when the xy plane is within 29 deg of horizontal
	assign cand_ztilt = amax_q8 < PW'(az) * PW'(orient_pkg::TAN29_Q8);
	// any axis above 1.25 g
	assign over_limit = (ax_q8 > LIMIT_THR) || (ay_q8 > LIMIT_THR) || (az_q8 > LIMIT_THR);

endmodule : orient_classify

// ===== verilog/orient_debounce.sv
// orient_debounce: debounce counter that gates when a new orientation is committed
`timescale 1ns/100ps
module orient_debounce (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic step_tick,
	input wire logic restart,
	input wire logic differ,
	input wire logic mode_clear,
	input wire logic [7:0] limit,
	output logic commit
);
	logic [7:0] count;
	logic [7:0] next_count;
	logic [8:0] count_inc;
	logic reach;

	assign count_inc = {1'b0, count} + 9'h001;
	assign reach = count_inc >= {1'b0, limit};
	assign commit = step_tick & differ & reach & ~restart;

	// ==========================================================
	// count up while the condition holds, decrement or clear when it drops
	always_comb begin
		next_count = count;
		if (restart) begin
			next_count = 8'h00;
		end else if (step_tick) begin
			if (differ) begin
				next_count = reach ? 8'h00 : count_inc[7:0];
			end else if (mode_clear) begin
				next_count = 8'h00;
			end else if (count != 8'h00) begin
				next_count = count - 8'h01;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			count <= 8'h00;
		end else begin
			count <= next_count;
		end
	end

endmodule : orient_debounce

// ===== verilog/orientation_detect_regs.sv
// orientation_detect_regs: orientation detection with its APB register file
//
// Notes on behaviour
// - reading the status register clears the change flag and the event output.
// - status bit 7 is one when code, facing or lockout changed.
// - code 00 portrait up, 01 portrait down, 10 landscape right, 11 left.
// - status bit 0 is facing: 0 front, 1 back.
// - status bit 6 is one when the tilt lockout angle is exceeded.
// - facing, code and lockout are zero after reset.
// - change flag sets after the first evaluation following standby to active.
// - code, facing and lockout keep updating while the flag is set.
// - reported orientation holds while any axis exceeds 1.25 g.
// - config bit 7 is debounce mode (reset 1), bit 6 enable.
// - when the condition drops, mode 0 decrements, mode 1 clears the counter.
// - detection runs only while enabled; enable resets to zero.
// - debounce count register, reset zero, sets latency as count times step.
// - every wake to sleep or sleep to wake change resets the counter.
// - debounce step follows sample rate and oversampling mode.
// - compensation bits 7:6 read the fixed facing trip code 01.
// - compensation bits 2:0 read the fixed tilt limit code 100.
// - threshold bits 7:3 read the fixed trip code 1_0000.
// - threshold bits 2:0 read the fixed margin code 100.
// - landscape to portrait at 59 deg, portrait to landscape at 31 deg.
//
// Added by the designer: register access over APB.
`timescale 1ns/100ps
module orientation_detect_regs #(
	parameter int AW = 12,
	parameter int ONE_G = 1024,
	parameter int STEP_BASE_CYCLES = orient_pkg::STEP_BASE_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [AW-1:0] accel_x,
	input wire logic [AW-1:0] accel_y,
	input wire logic [AW-1:0] accel_z,
	input wire logic device_active,
	input wire logic sleep_state,
	input wire logic [2:0] output_sample_rate,
	input wire logic [1:0] oversampling_mode,
	output logic orient_event
);
	localparam int BW = $clog2(STEP_BASE_CYCLES + 1);
	localparam logic [BW-1:0] BASE_LAST = BW'(STEP_BASE_CYCLES - 1);

	// ==========================================================
	// state declarations
	logic debounce_mode_sel;
	logic orient_detect_enable;
	logic [7:0] debounce_count_value;
	logic next_debounce_mode_sel;
	logic next_orient_detect_enable;
	logic [7:0] next_debounce_count_value;

	logic orient_change_flag;
	logic ztilt_trip_flag;
	logic [1:0] orient_code;
	logic facing_bit;
	logic first_pending;
	logic active_q;
	logic sleep_q;
	logic next_orient_change_flag;
	logic next_ztilt_trip_flag;
	logic [1:0] next_orient_code;
	logic next_facing_bit;
	logic next_first_pending;

	logic [BW-1:0] base_count;
	logic [7:0] mult_count;
	logic [BW-1:0] next_base_count;
	logic [7:0] next_mult_count;

	logic [31:0] next_prdata;

	// ==========================================================
	// bus decode
	logic [5:0] reg_idx;
	logic aligned;
	logic mapped;
	logic access;
	logic wr_access;
	logic rd_setup;
	logic status_read;
	logic [7:0] status_value;
	logic [7:0] read_value;

	assign reg_idx = paddr[7:2];
	assign aligned = paddr[1:0] == 2'h0;
	assign mapped = aligned && (reg_idx >= orient_pkg::IDX_STATUS) && (reg_idx <= orient_pkg::IDX_THRESHOLD);
	assign access = psel & penable;
	assign wr_access = access & pwrite & mapped;
	assign rd_setup = psel & ~penable & ~pwrite;
	// clear on the completing edge, and only if nothing was committed after the setup snapshot
	assign status_read = access & ~pwrite & mapped & (reg_idx == orient_pkg::IDX_STATUS) & (prdata[7:0] == status_value);

	// zero wait states; an unmapped or misaligned address answers with an error
	assign pready = 1'b1;
	assign pslverr = access & ~mapped;

	// ==========================================================
	// status word and read mux
	always_comb begin
		status_value = 8'h00;
		status_value[orient_pkg::STAT_CHANGE_BIT] = orient_change_flag;
		status_value[orient_pkg::STAT_ZTILT_BIT] = ztilt_trip_flag;
		status_value[orient_pkg::STAT_CODE_LSB +: 2] = orient_code;
		status_value[orient_pkg::STAT_FACING_BIT] = facing_bit;
	end

	always_comb begin
		read_value = 8'h00;
		case (reg_idx)
			orient_pkg::IDX_STATUS: begin
				read_value = status_value;
			end
			orient_pkg::IDX_CONFIG: begin
				read_value[orient_pkg::CFG_MODE_BIT] = debounce_mode_sel;
				read_value[orient_pkg::CFG_ENABLE_BIT] = orient_detect_enable;
			end
			orient_pkg::IDX_DBNC_COUNT: begin
				read_value = debounce_count_value;
			end
			orient_pkg::IDX_FACING_TILT: begin
				read_value[orient_pkg::CMP_FACING_LSB +: 2] = orient_pkg::FACING_TRIP_CODE;
				read_value[2:0] = orient_pkg::ZTILT_LIMIT_CODE;
			end
			orient_pkg::IDX_THRESHOLD: begin
				read_value[orient_pkg::THS_TRIP_LSB +: 5] = orient_pkg::ORIENT_TRIP_CODE;
				read_value[2:0] = orient_pkg::TRIP_MARGIN_CODE;
			end
			default: begin
				read_value = 8'h00;
			end
		endcase
		if (!aligned) begin
			read_value = 8'h00;
		end
	end

	// read data is captured in the setup cycle so prdata comes from a flop
	always_comb begin
		next_prdata = prdata;
		if (rd_setup) begin
			next_prdata = {24'h000000, read_value};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			prdata <= 32'h00000000;
		end else begin
			prdata <= next_prdata;
		end
	end

	// ==========================================================
	// configuration registers; read-only offsets simply have no write path
	always_comb begin
		next_debounce_mode_sel = debounce_mode_sel;
		next_orient_detect_enable = orient_detect_enable;
		next_debounce_count_value = debounce_count_value;
		if (wr_access) begin
			case (reg_idx)
				orient_pkg::IDX_CONFIG: begin
					next_debounce_mode_sel = pwdata[orient_pkg::CFG_MODE_BIT];
					next_orient_detect_enable = pwdata[orient_pkg::CFG_ENABLE_BIT];
				end
				orient_pkg::IDX_DBNC_COUNT: begin
					next_debounce_count_value = pwdata[7:0];
				end
				default: begin
					next_debounce_mode_sel = debounce_mode_sel;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			debounce_mode_sel <= orient_pkg::MODE_RST;
			orient_detect_enable <= orient_pkg::ENABLE_RST;
			debounce_count_value <= orient_pkg::DBNC_RST;
		end else begin
			debounce_mode_sel <= next_debounce_mode_sel;
			orient_detect_enable <= next_orient_detect_enable;
			debounce_count_value <= next_debounce_count_value;
		end
	end

	// ==========================================================
	// debounce step timer: base step of 1.25 ms times a rate dependent multiplier
	logic running;
	logic base_done;
	logic [7:0] step_len;
	logic step_tick;

	assign running = orient_detect_enable & device_active;
	assign step_len = orient_pkg::step_mult(output_sample_rate, oversampling_mode);
	assign base_done = base_count == BASE_LAST;
	assign step_tick = running & base_done & (mult_count + 8'h01 >= step_len);

	// a rate change mid step only shortens or lengthens the step in progress
	always_comb begin
		next_base_count = base_count;
		next_mult_count = mult_count;
		if (!running) begin
			next_base_count = '0;
			next_mult_count = 8'h00;
		end else if (base_done) begin
			next_base_count = '0;
			next_mult_count = step_tick ? 8'h00 : mult_count + 8'h01;
		end else begin
			next_base_count = base_count + BW'(1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			base_count <= '0;
			mult_count <= 8'h00;
		end else begin
			base_count <= next_base_count;
			mult_count <= next_mult_count;
		end
	end

	// ==========================================================
	// classification and debounce
	logic [1:0] cand_code;
	logic cand_facing;
	logic cand_ztilt;
	logic over_limit;
	logic [1:0] eff_code;
	logic differ;
	logic eval_tick;
	logic restart;
	logic commit;
	logic first_eval;

	orient_classify #(
		.AW(AW),
		.ONE_G(ONE_G)
	) u_classify (
		.accel_x(accel_x),
		.accel_y(accel_y),
		.accel_z(accel_z),
		.cur_code(orient_code),
		.cur_facing(facing_bit),
		.cand_code(cand_code),
		.cand_facing(cand_facing),
		.cand_ztilt(cand_ztilt),
		.over_limit(over_limit)
	);

	// under lockout the portrait/landscape code is not allowed to move
	assign eff_code = cand_ztilt ? orient_code : cand_code;
	assign differ = (eff_code != orient_code) | (cand_facing != facing_bit) | (cand_ztilt != ztilt_trip_flag);
	// above 1.25 g the evaluation is skipped outright, so the counter freezes too
	assign eval_tick = step_tick & ~over_limit;
	assign restart = (sleep_state != sleep_q) | (device_active & ~active_q);
	assign first_eval = eval_tick & first_pending & ~restart;

	orient_debounce u_debounce (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.step_tick(eval_tick),
		.restart(restart),
		.differ(differ),
		.mode_clear(debounce_mode_sel),
		.limit(debounce_count_value),
		.commit(commit)
	);

	// ==========================================================
	// reported orientation and change flag
	always_comb begin
		next_orient_code = orient_code;
		next_facing_bit = facing_bit;
		next_ztilt_trip_flag = ztilt_trip_flag;
		next_first_pending = first_pending;
		next_orient_change_flag = orient_change_flag;
		if (device_active & ~active_q) begin
			next_first_pending = 1'b1;
		end else if (first_eval) begin
			next_first_pending = 1'b0;
		end
		// the flag does not freeze the fields
		if (commit | first_eval) begin
			next_orient_code = eff_code;
			next_facing_bit = cand_facing;
			next_ztilt_trip_flag = cand_ztilt;
		end
		// a new change in the clearing cycle keeps the flag set
		if (status_read) begin
			next_orient_change_flag = 1'b0;
		end
		if ((commit & differ) | first_eval) begin
			next_orient_change_flag = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			orient_code <= orient_pkg::CODE_RST;
			facing_bit <= 1'b0;
			ztilt_trip_flag <= 1'b0;
			orient_change_flag <= 1'b0;
			first_pending <= 1'b0;
			active_q <= 1'b0;
			sleep_q <= 1'b0;
		end else begin
			orient_code <= next_orient_code;
			facing_bit <= next_facing_bit;
			ztilt_trip_flag <= next_ztilt_trip_flag;
			orient_change_flag <= next_orient_change_flag;
			first_pending <= next_first_pending;
			active_q <= device_active;
			sleep_q <= sleep_state;
		end
	end

	// event level follows the flag, so a status read drops it
	assign orient_event = orient_change_flag;

endmodule : orientation_detect_regs

// ===== tb/orientation_detect_regs_checker.sv
// checker: concurrent port checks for the orientation detection block
`timescale 1ns/100ps
module orientation_detect_regs_checker #(
	parameter int AW = 12,
	parameter int ONE_G = 1024
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [AW-1:0] accel_x,
	input wire logic [AW-1:0] accel_y,
	input wire logic [AW-1:0] accel_z,
	input wire logic device_active,
	input wire logic sleep_state,
	input wire logic [2:0] output_sample_rate,
	input wire logic [1:0] oversampling_mode,
	input wire logic orient_event
);
	// ==========================================================
	// helper terms
	function automatic int mag(input logic [AW-1:0] v);
		int s;
		s = int'($signed(v));
		return s < 0 ? -s : s;
	endfunction : mag
	logic access;
	logic bad_addr;
	logic rd_stat;
	logic over;
	// an unmapped or misaligned word is the only cause of an error response
	assign access = psel && penable;
	assign bad_addr = paddr[1:0] != 2'h0 || paddr[7:2] < orient_pkg::IDX_STATUS || paddr[7:2] > orient_pkg::IDX_THRESHOLD;
	assign rd_stat = access && !pwrite && paddr == 8'h40;
	assign over = mag(accel_x) > ONE_G * 5 / 4 || mag(accel_y) > ONE_G * 5 / 4 || mag(accel_z) > ONE_G * 5 / 4;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// ==========================================================
	// assertions
	chk_ready_always: assert property (pready) else $error("pready low");
	chk_err_addr: assert property (access |-> pslverr == bad_addr) else $error("error response wrong");
	chk_err_idle: assert property (!access |-> !pslverr) else $error("error outside access");
	chk_upper_zero: assert property (prdata[31:8] == 24'h000000) else $error("read data upper bits set");
	chk_reset_clean: assert property ($rose(rst_b) |-> !orient_event && prdata == 32'h0) else $error("reset state");
	chk_flag_holds: assert property (orient_event && !rd_stat |=> orient_event) else $error("flag lost");
	chk_read_clears: assert property (rd_stat && over && $past(over) |=> !orient_event)
		else $error("flag not cleared by read");
	chk_freeze_limit: assert property (over && $past(over) && !orient_event |=> !orient_event)
		else $error("change above limit");
	chk_rise_active: assert property ($rose(orient_event) |-> $past(device_active))
		else $error("change in standby");
	cov_read_flag: cover property (rd_stat && orient_event);
	cov_event: cover property ($rose(orient_event));
	cov_err: cover property (access && pslverr);
endmodule : orientation_detect_regs_checker

bind orientation_detect_regs orientation_detect_regs_checker #(.AW(AW), .ONE_G(ONE_G)) checker_i (.sys_clk(sys_clk),
	.rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z),
	.device_active(device_active), .sleep_state(sleep_state), .output_sample_rate(output_sample_rate),
	.oversampling_mode(oversampling_mode), .orient_event(orient_event));

// ===== tb/orientation_detect_regs_test.sv
// testbench: registers, detection and debounce timing against an integer model
`timescale 1ns/100ps
module orientation_detect_regs_test;
	`define CHECK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
	logic sys_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q, seed = 32'hCF6378C4;
	logic pready, pslverr, orient_event, device_active = 1'b0, sleep_state = 1'b0;
	logic [11:0] accel_x = 12'h000, accel_y = 12'h000, accel_z = 12'h000;
	logic [2:0] output_sample_rate = 3'h0;
	logic [1:0] oversampling_mode = 2'h0;
	int fails = 0, samples_checked = 0, cycles = 0, lat, mcode = 0, mfacing = 0, mlock = 0, mflag = 0;
	logic [7:0] ta [7] = '{8'h40, 8'h44, 8'h48, 8'h4C, 8'h50, 8'h60, 8'h41};
	logic [7:0] tr [7] = '{8'h00, 8'h80, 8'h00, 8'h44, 8'h84, 8'h00, 8'h00};
	logic [7:0] tw [7] = '{8'h00, 8'hC0, 8'hFF, 8'h44, 8'h84, 8'h00, 8'h00};
	int lr [4] = '{0, 1, 5, 2}, lo [4] = '{0, 0, 2, 3}, lm [4] = '{1, 2, 2, 4}, lc [4] = '{3, 2, 2, 2};
	orientation_detect_regs #(.STEP_BASE_CYCLES(4)) dut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z), .device_active(device_active),
		.sleep_state(sleep_state), .output_sample_rate(output_sample_rate), .oversampling_mode(oversampling_mode),
		.orient_event(orient_event));
	// ==========================================================
	// clock, timeout and verdict
	always #12.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 30000) begin
			fails++;
			final_report();
		end
	end
	task final_report;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	// ==========================================================
	// apb transfer: held until pready is seen at a rising edge
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : xfer
	// ==========================================================
	// integer model of one evaluation; hysteresis keeps the current class
	function automatic int iabs(int v);
		return v < 0 ? -v : v;
	endfunction : iabs
	task model_eval(int x, int y, int z);
		int ax, ay, az, c, f, l;
		ax = iabs(x);
		ay = iabs(y);
		az = iabs(z);
		if (ax > 1280 || ay > 1280 || az > 1280) return;
		l = (ax > ay ? ax : ay) * 256 < 142 * az;
		f = az * 256 >= 66 * 1024 ? z < 0 : mfacing;
		c = mcode;
		if (!l && mcode < 2 && ay * 256 < 154 * ax) c = 2 + (x < 0);
		else if (!l && mcode >= 2 && ay * 256 > 426 * ax) c = y < 0;
		else if (!l) c = mcode < 2 ? y < 0 : 2 + (x < 0);
		if (c != mcode || f != mfacing || l != mlock) mflag = 1;
		mcode = c;
		mfacing = f;
		mlock = l;
	endtask : model_eval
	task drive(int x, int y, int z);
		accel_x <= 12'(x);
		accel_y <= 12'(y);
		accel_z <= 12'(z);
		model_eval(x, y, z);
		model_eval(x, y, z);
	endtask : drive
	task check_status;
		xfer(1'b0, 8'h40, 32'h0);
		`CHECK("status", 32'(mflag * 128 + mlock * 64 + mcode * 2 + mfacing), q)
		mflag = 0;
	endtask : check_status
	task wait_event(int lim);
		lat = 0;
		while (orient_event !== 1'b1 && lat < lim) begin
			@(posedge sys_clk);
			lat++;
		end
	endtask : wait_event
	// ==========================================================
	// main sequence
	initial begin
		repeat (5) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		// reset values, then all-ones writes; read-only and unmapped words keep their value
		for (int i = 0; i < 7; i++) begin
			xfer(1'b0, ta[i], 32'h0);
			`CHECK("reset value", 32'(tr[i]), q)
			xfer(1'b1, ta[i], 32'hFFFFFFFF);
			xfer(1'b0, ta[i], 32'h0);
			`CHECK("after write", 32'(tw[i]), q)
			`CHECK("error", i >= 5, err)
		end
		xfer(1'b1, 8'h44, 32'h80);
		xfer(1'b1, 8'h48, 32'h0);
		// active but disabled: nothing is evaluated
		device_active <= 1'b1;
		accel_x <= 12'h3E8;
		repeat (40) @(posedge sys_clk);
		check_status();
		xfer(1'b1, 8'h44, 32'hC0);
		model_eval(1000, 0, 0);
		mflag = 1;
		wait_event(60);
		// over the g limit the status freezes; the read still clears the flag
		drive(1300, 0, 0);
		repeat (20) @(posedge sys_clk);
		check_status();
		check_status();
		`CHECK("event", 1'b0, orient_event)
		drive(0, 0, -1000);
		wait_event(60);
		check_status();
		// second change while the flag is still set
		drive(1000, 0, 0);
		wait_event(60);
		drive(-1000, 0, 0);
		repeat (20) @(posedge sys_clk);
		check_status();
		// debounce latency over rates and oversampling modes
		for (int i = 0; i < 4; i++) begin
			output_sample_rate <= 3'(lr[i]);
			oversampling_mode <= 2'(lo[i]);
			xfer(1'b1, 8'h48, 32'(lc[i]));
			if (i % 2 == 0) drive(0, -1000, 0);
			else drive(1000, 0, 0);
			wait_event(200);
			`CHECK("latency", 1'b1, lat > (lc[i] - 1) * 4 * lm[i] && lat <= lc[i] * 4 * lm[i] + 3)
			check_status();
		end
		output_sample_rate <= 3'h0;
		oversampling_mode <= 2'h0;
		xfer(1'b1, 8'h48, 32'h0);
		// random postures, some beyond the g limit, with wake and sleep toggling
		for (int i = 0; i < 10; i++) begin
			seed = lfsr(lfsr(seed));
			sleep_state <= i % 2;
			drive(int'(seed[11:0]) % 2800 - 1400, int'(seed[23:12]) % 2800 - 1400, int'(seed[31:20]) % 2800 - 1400);
			repeat (30) @(posedge sys_clk);
			check_status();
		end
		// mode 0: a one-step dropout only decrements, so the next two differing steps commit
		drive(1000, 0, 0);
		repeat (20) @(posedge sys_clk);
		check_status();
		xfer(1'b1, 8'h48, 32'h3);
		xfer(1'b1, 8'h44, 32'h40);
		for (int k = 0; k < 3; k++) begin
			accel_x <= (k == 1) ? 12'h3E8 : 12'h000;
			accel_y <= (k == 1) ? 12'h000 : 12'hC18;
			repeat ((k == 1) ? 4 : 8) @(posedge sys_clk);
		end
		model_eval(0, -1000, 0);
		check_status();
		final_report();
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h80200003 : 32'h0);
	endfunction : lfsr
endmodule : orientation_detect_regs_test
